// ---- core/rpr_receiver.sv ----
// Purpose: remote-control pulse receiver with an AHB-Lite register port
// Assumes: 20 MHz clock; sampling clocks far slower than the bus clock
// Notes: clock gating is modelled as a hold enable on all logic but block_on, the bus port, the pin synchronisers and irq
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "rpr_map.svh"
module rpr_receiver import rpr_pkg::*; #(
    parameter int FRAME_BITS = `RPR_FRAME_BITS
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // sampling clock sources and remote input
    input wire logic lf_clk_pin,
    input wire logic timer_out_pin,
    input wire logic remote_pin,
    // interrupt request
    output logic irq
);
    if (FRAME_BITS != `RPR_FRAME_BITS) begin : g_chk
        $error("rpr_receiver serves a 72-bit frame only");
    end

    // -------------------------------------------------------------
    // register storage
    // -------------------------------------------------------------
    logic [1:0] block_on_r;
    logic rx_on_r;
    logic [31:0] lead_cfg_r;
    logic [31:0] mode_cfg_r;
    logic [31:0] thr_cfg_r;
    logic [31:0] noise_cfg_r;
    logic [6:0] end1_r;
    logic [6:0] end2_r;
    logic [6:0] end3_r;
    logic fsel_r;
    logic [71:0] buf_r;
    logic [3:0] flags_r;
    logic leader_seen_r;
    logic [6:0] count_r;

    // bus phase capture
    logic wr_ph_r;
    logic rd_ph_r;
    logic [5:0] addr_r;
    logic [31:0] rd_mux;

    // -------------------------------------------------------------
    // field views
    // -------------------------------------------------------------
    wire block_on = block_on_r[0];
    wire [7:0] leader_cycle_max = lead_cfg_r[31:24];
    wire [7:0] leader_cycle_min = lead_cfg_r[23:16];
    wire [7:0] leader_low_max = lead_cfg_r[15:8];
    wire [7:0] leader_low_min = lead_cfg_r[7:0];
    wire leader_irq_on = mode_cfg_r[`RPR_BIT_LEADER_IRQ];
    wire fall_edge_irq_on = mode_cfg_r[`RPR_BIT_FALL_IRQ];
    wire leaderless_allow = mode_cfg_r[`RPR_BIT_LEADERLESS];
    wire phase_mode_sel = mode_cfg_r[`RPR_BIT_PHASE];
    wire [7:0] excess_low_limit = mode_cfg_r[15:8];
    wire [7:0] bit_cycle_limit = mode_cfg_r[7:0];
    wire [6:0] upper_threshold = thr_cfg_r[14:8];
    wire [6:0] lower_threshold = thr_cfg_r[6:0];
    wire input_invert = noise_cfg_r[`RPR_BIT_INVERT];
    wire [3:0] noise_filter_count = noise_cfg_r[3:0];

    // -------------------------------------------------------------
    // bus decode
    // -------------------------------------------------------------
    wire addr_take = hsel & htrans[1] & hready;
    wire wr_take = addr_take & hwrite;
    wire rd_take = addr_take & ~hwrite;
    // configuration writes need the block's clocks, so they are dropped while block_on is low
    wire cfg_wr = wr_ph_r & block_on;
    wire wr_block = wr_ph_r & (addr_r == `RPR_OFS_BLOCK_ON);

    // read mux; unmapped words and reserved bits read zero
    always_comb begin
        unique case (addr_r)
            `RPR_OFS_BLOCK_ON: rd_mux = {30'h0, block_on_r};
            `RPR_OFS_RX_ON: rd_mux = {31'h0, rx_on_r};
            `RPR_OFS_BUF_LOW: rd_mux = buf_r[31:0];
            `RPR_OFS_BUF_MID: rd_mux = buf_r[63:32];
            `RPR_OFS_BUF_HIGH: rd_mux = {24'h0, buf_r[71:64]};
            `RPR_OFS_LEADER: rd_mux = lead_cfg_r;
            `RPR_OFS_MODE: rd_mux = mode_cfg_r;
            `RPR_OFS_THRESH: rd_mux = thr_cfg_r;
            `RPR_OFS_NOISE: rd_mux = noise_cfg_r;
            `RPR_OFS_STATUS: rd_mux = {16'h0, flags_r, 4'h0, leader_seen_r, count_r};
            `RPR_OFS_END1: rd_mux = {25'h0, end1_r};
            `RPR_OFS_END2: rd_mux = {25'h0, end2_r};
            `RPR_OFS_END3: rd_mux = {25'h0, end3_r};
            `RPR_OFS_FSEL: rd_mux = {31'h0, fsel_r};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // address phase capture; reads insert one wait state so data follow writes
    always_ff @(posedge clock) begin
        if (reset) begin
            wr_ph_r <= 1'b0;
            rd_ph_r <= 1'b0;
            addr_r <= 6'h00;
            hreadyout <= 1'b1;
            hrdata <= 32'h00000000;
            hresp <= 1'b0;
        end else begin
            wr_ph_r <= wr_take;
            rd_ph_r <= rd_take;
            if (addr_take) begin
                addr_r <= (haddr[31:6] == 26'h0) ? haddr[5:0] : 6'h3C;
            end
            hreadyout <= ~rd_take;
            if (rd_ph_r) begin
                hrdata <= rd_mux;
            end
        end
    end

    // block_on keeps its clock always
    always_ff @(posedge clock) begin
        if (reset) begin
            block_on_r <= 2'b00;
        end else if (wr_block) begin
            block_on_r <= hwdata[1:0];
        end
    end

    // configuration registers hold their values while the block is off
    always_ff @(posedge clock) begin
        if (reset) begin
            rx_on_r <= 1'b0;
            lead_cfg_r <= 32'h00000000;
            mode_cfg_r <= `RPR_MODE_RESET;
            thr_cfg_r <= 32'h00000000;
            noise_cfg_r <= 32'h00000000;
            end1_r <= 7'h00;
            end2_r <= 7'h00;
            end3_r <= 7'h00;
            fsel_r <= 1'b0;
        end else if (cfg_wr) begin
            unique case (addr_r)
                `RPR_OFS_RX_ON: rx_on_r <= hwdata[0];
                `RPR_OFS_LEADER: lead_cfg_r <= hwdata;
                `RPR_OFS_MODE: mode_cfg_r <= hwdata & `RPR_MODE_MASK;
                `RPR_OFS_THRESH: thr_cfg_r <= hwdata & `RPR_THRESH_MASK;
                `RPR_OFS_NOISE: noise_cfg_r <= hwdata & `RPR_NOISE_MASK;
                `RPR_OFS_END1: end1_r <= hwdata[6:0];
                `RPR_OFS_END2: end2_r <= hwdata[6:0];
                `RPR_OFS_END3: end3_r <= hwdata[6:0];
                `RPR_OFS_FSEL: fsel_r <= hwdata[0];
                default: ;
            endcase
        end
    end

    // -------------------------------------------------------------
    // pin synchronisers and sampling tick
    // -------------------------------------------------------------
    logic lf_lvl;
    logic tmr_lvl;
    logic rmt_lvl;
    logic samp_d_r;

    rpr_pin_sync u_sync_lf (.clock(clock), .reset(reset), .pin(lf_clk_pin), .level(lf_lvl));
    rpr_pin_sync u_sync_tmr (.clock(clock), .reset(reset), .pin(timer_out_pin), .level(tmr_lvl));
    rpr_pin_sync u_sync_rmt (.clock(clock), .reset(reset), .pin(remote_pin), .level(rmt_lvl));

    // rising edge of the chosen sampling clock is one sample tick
    wire samp_lvl = fsel_r ? tmr_lvl : lf_lvl;
    wire tick = block_on & samp_lvl & ~samp_d_r;
    wire rx_step = tick & rx_on_r;

    always_ff @(posedge clock) begin
        if (reset) begin
            samp_d_r <= 1'b0;
        end else if (block_on) begin
            samp_d_r <= samp_lvl;
        end
    end

    // -------------------------------------------------------------
    // noise filter
    // -------------------------------------------------------------
    logic filt_r;
    logic [3:0] nf_cnt_r;
    wire raw = rmt_lvl ^ input_invert;
    wire differ = raw != filt_r;
    wire [3:0] nf_inc = nf_cnt_r + 4'h1;
    wire nf_done = (nf_inc >= noise_filter_count);
    wire filt_nxt = (differ & nf_done) ? raw : filt_r;
    wire fall = rx_step & filt_r & ~filt_nxt;

    always_ff @(posedge clock) begin
        if (reset) begin
            filt_r <= 1'b1;
            nf_cnt_r <= 4'h0;
        end else if (rx_step) begin
            filt_r <= filt_nxt;
            nf_cnt_r <= (differ & ~nf_done) ? nf_inc : 4'h0;
        end
    end

    // -------------------------------------------------------------
    // width measurement
    // -------------------------------------------------------------
    logic [9:0] cyc_r;
    logic [9:0] low_r;
    wire [9:0] cyc_inc = (cyc_r == 10'h3FF) ? cyc_r : cyc_r + 10'h001;
    wire [9:0] low_inc = (low_r == 10'h3FF) ? low_r : low_r + 10'h001;

    // cycle counts ticks between falls, low counts ticks spent low
    always_ff @(posedge clock) begin
        if (reset) begin
            cyc_r <= 10'h000;
            low_r <= 10'h000;
        end else if (rx_step) begin
            cyc_r <= fall ? 10'h000 : cyc_inc;
            low_r <= fall ? 10'h000 : (filt_r ? low_r : low_inc);
        end
    end

    // -------------------------------------------------------------
    // leader check and bit decode
    // -------------------------------------------------------------
    rpr_state_t st_r;
    rpr_state_t st_nxt;
    logic [71:0] bits_r;
    logic [6:0] nbits_r;

    wire no_leader = leader_cycle_max == 8'h00;
    wire lead_cyc_ok = (cyc_inc >= {leader_cycle_min, 2'b00})
                     & (cyc_inc <= {leader_cycle_max, 2'b00});
    wire lead_low_ok = (leader_low_max == 8'h00)
                     | ((low_r >= {leader_low_min, 2'b00})
                     & (low_r <= {leader_low_max, 2'b00}));
    wire short_low = low_r < {leader_low_min, 2'b00};
    wire lead_evt = fall & (st_r == RPR_ST_LEAD) & ~no_leader & lead_cyc_ok & lead_low_ok;
    wire as_data = fall & (st_r == RPR_ST_LEAD) & ~lead_evt
                 & leaderless_allow & short_low;
    wire data_bit = (fall & (st_r == RPR_ST_DATA)) | as_data;

    // one bit in cycle mode, a two-bit pattern in phase mode
    wire above_low = cyc_inc > {3'b000, lower_threshold};
    wire above_up = phase_mode_sel & (cyc_inc > {3'b000, upper_threshold});
    wire [1:0] pattern = above_up ? 2'b10 : (above_low ? 2'b01 : 2'b00);
    wire [71:0] bits_nxt = phase_mode_sel ? {bits_r[69:0], pattern}
                                          : {bits_r[70:0], above_low};
    wire [7:0] nbits_sum = {1'b0, nbits_r} + (phase_mode_sel ? 8'h02 : 8'h01);
    wire [6:0] nbits_nxt = nbits_sum[7] ? `RPR_COUNT_SAT : nbits_sum[6:0];

    // frame completion
    wire lo_done = rx_step & (st_r == RPR_ST_DATA) & ~filt_r
                 & (excess_low_limit != `RPR_LIMIT_OFF)
                 & (low_r == {2'b00, excess_low_limit});
    wire end_any = (end1_r != 7'h00) | (end2_r != 7'h00) | (end3_r != 7'h00);
    wire end_ok = ~end_any | ((end1_r != 7'h00) & (nbits_r == end1_r))
                | ((end2_r != 7'h00) & (nbits_r == end2_r))
                | ((end3_r != 7'h00) & (nbits_r == end3_r));
    wire dmax_done = rx_step & (st_r == RPR_ST_DATA) & ~fall
                   & (bit_cycle_limit != `RPR_LIMIT_OFF)
                   & (cyc_r == {2'b00, bit_cycle_limit}) & end_ok;
    wire done = lo_done | dmax_done;
    wire fall_evt = fall & fall_edge_irq_on;
    wire irq_evt = (lead_evt & leader_irq_on) | fall_evt | done;

    // sequencing
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            RPR_ST_IDLE: begin
                if (fall) begin
                    st_nxt = no_leader ? RPR_ST_DATA : RPR_ST_LEAD;
                end
            end
            RPR_ST_LEAD: begin
                if (lead_evt | as_data) begin
                    st_nxt = RPR_ST_DATA;
                end
            end
            RPR_ST_DATA: begin
                if (done) begin
                    st_nxt = RPR_ST_IDLE;
                end
            end
            default: st_nxt = RPR_ST_IDLE;
        endcase
        if (!rx_on_r) begin
            st_nxt = RPR_ST_IDLE;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st_r <= RPR_ST_IDLE;
        end else if (block_on) begin
            st_r <= st_nxt;
        end
    end

    // working shift register and bit count
    always_ff @(posedge clock) begin
        if (reset) begin
            bits_r <= 72'h0;
            nbits_r <= 7'h00;
        end else if (lead_evt | (fall & (st_r == RPR_ST_IDLE))) begin
            bits_r <= 72'h0;
            nbits_r <= 7'h00;
        end else if (data_bit) begin
            bits_r <= bits_nxt;
            nbits_r <= nbits_nxt;
        end
    end

    // result buffer updated on frame completion, status flags on each interrupt event
    always_ff @(posedge clock) begin
        if (reset) begin
            buf_r <= 72'h0;
            flags_r <= 4'h0;
            leader_seen_r <= 1'b0;
            count_r <= 7'h00;
            irq <= 1'b0;
        end else begin
            irq <= irq_evt;
            if (lead_evt) begin
                leader_seen_r <= 1'b1;
            end else if (fall & (st_r == RPR_ST_IDLE)) begin
                leader_seen_r <= 1'b0;
            end
            if (irq_evt) begin
                flags_r <= {lead_evt, lo_done, dmax_done, fall_evt};
            end
            if (done) begin
                buf_r <= bits_r;
                count_r <= nbits_r;
            end
        end
    end

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_read_addr;
        rd_take;
    endsequence
    sequence s_read_data;
        !hreadyout ##1 hreadyout;
    endsequence

    a_read_wait: assert property (s_read_addr |=> s_read_data)
        else $error("read did not take exactly one wait state");
    a_irq_pulse: assert property (irq |=> !irq)
        else $error("interrupt held longer than one clock");
    a_off_quiet: assert property (!block_on ##1 !block_on |-> !irq)
        else $error("interrupt while block is off");
    a_off_frozen: assert property (!block_on && !wr_block |=> $stable(st_r))
        else $error("state moved while block is off");
    a_cfg_kept: assert property ($fell(block_on) ##1 !block_on |-> $stable(lead_cfg_r))
        else $error("configuration changed while block is off");
    a_leader_irq: assert property (lead_evt && leader_irq_on |=> irq && flags_r[3])
        else $error("leader did not raise its interrupt");
    a_fall_irq: assert property (fall && fall_edge_irq_on |=> irq && flags_r[0])
        else $error("falling edge did not raise its interrupt");
    a_cycle_bit: assert property (data_bit && !phase_mode_sel && above_low |=> bits_r[0])
        else $error("long cycle did not decode as one");
    a_phase_pat: assert property (data_bit && phase_mode_sel && above_up
        |=> bits_r[1:0] == 2'b10)
        else $error("long phase cycle did not decode as 10");
    a_upper_off: assert property (data_bit && !phase_mode_sel && !above_low
        && (cyc_inc > {3'b000, upper_threshold}) |=> !bits_r[0])
        else $error("upper threshold used in cycle mode");
    a_low_off: assert property (excess_low_limit == `RPR_LIMIT_OFF |-> !lo_done)
        else $error("disabled excess low ended a frame");
    a_dmax_off: assert property (bit_cycle_limit == `RPR_LIMIT_OFF |-> !dmax_done)
        else $error("disabled cycle limit ended a frame");
    a_frame_copy: assert property (done |=> buf_r == $past(bits_r) && irq
        && st_r == RPR_ST_IDLE)
        else $error("completed frame not copied to the buffer");
    a_short_low: assert property (as_data |=> st_r == RPR_ST_DATA && nbits_r != 7'h00)
        else $error("short low not taken as a data bit");
    a_filter_pass: assert property (rx_step && noise_filter_count == 4'h0 && differ
        |=> filt_r == $past(raw))
        else $error("unfiltered input did not pass at once");
endmodule // rpr_receiver
`default_nettype wire

// ---- pkg/rpr_map.svh ----
// Purpose: offsets, field positions, reset values and counts of the pulse receiver
// Assumes: included by bare name; definitions only
// Notes: byte offsets on a 32-bit word bus
//
// Contract
// - input sampled on ticks of the low-frequency clock or the timer output
// - block_on bit 0 enables; while off, all logic except enable register, bus port, pin synchronisers and irq stands still
// - turning the block off leaves every configuration register unchanged
// - up to 72 received bits readable in three read-only buffer words
// - bits shift in msb first; newest bit sits at bit 0
// - leader cycle must lie between min and max fields times four samples
// - leader low width checked against max and min fields times four samples
// - with leaderless reception, a low shorter than min leader low is a data bit
// - control bit 31 enables leader interrupt, bit 30 falling edge interrupt
// - control bit 25 lets a frame start without any leader
// - control bit 24 picks cycle decoding or phase decoding
// - low lasting the excess-low field completes the frame; all ones disables it
// - bit cycle reaching the cycle-limit field completes the frame; all ones disables
// - cycle mode: cycle above lower threshold is a one, else a zero
// - phase mode: above upper gives 10, above lower gives 01, else 00
// - upper threshold only matters while phase mode is selected
// - filtered level changes after N equal samples of new level; N zero passes
// - input_invert bit 7 of the fourth control register inverts the input
// - a completed frame overwrites the buffer; receiver then waits for a leader
`ifndef RPR_MAP_SVH
`define RPR_MAP_SVH
`define RPR_OFS_BLOCK_ON 6'h00
`define RPR_OFS_RX_ON 6'h04
`define RPR_OFS_BUF_LOW 6'h08
`define RPR_OFS_BUF_MID 6'h0C
`define RPR_OFS_BUF_HIGH 6'h10
`define RPR_OFS_LEADER 6'h14
`define RPR_OFS_MODE 6'h18
`define RPR_OFS_THRESH 6'h1C
`define RPR_OFS_NOISE 6'h20
`define RPR_OFS_STATUS 6'h24
`define RPR_OFS_END1 6'h28
`define RPR_OFS_END2 6'h2C
`define RPR_OFS_END3 6'h30
`define RPR_OFS_FSEL 6'h34
`define RPR_MODE_RESET 32'h0000FFFF
`define RPR_MODE_MASK 32'hC300FFFF
`define RPR_THRESH_MASK 32'h00007F7F
`define RPR_NOISE_MASK 32'h0000008F
`define RPR_BIT_LEADER_IRQ 31
`define RPR_BIT_FALL_IRQ 30
`define RPR_BIT_LEADERLESS 25
`define RPR_BIT_PHASE 24
`define RPR_BIT_INVERT 7
`define RPR_LIMIT_OFF 8'hFF
`define RPR_COUNT_SAT 7'h7F
`define RPR_FRAME_BITS 72
`endif

// ---- pkg/rpr_pkg.sv ----
// Purpose: types shared by the pulse receiver
// Assumes: nothing
// Notes: receiver sequencing states
package rpr_pkg;
    typedef enum logic [1:0] {
        RPR_ST_IDLE = 2'b00, // waiting for the first falling edge
        RPR_ST_LEAD = 2'b01, // measuring a leader candidate
        RPR_ST_DATA = 2'b10  // collecting data bits
    } rpr_state_t;
endpackage

// ---- core/rpr_pin_sync.sv ----
// Purpose: three-flop synchroniser for one asynchronous input
// Assumes: pin changes slowly against clock
// Notes: the level moves only once the second and third flops agree
`timescale 1ns/1ns
`default_nettype none
module rpr_pin_sync (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // asynchronous pin and its clean level
    input wire logic pin,
    output logic level
);
    logic ff1_r;
    logic ff2_r;
    logic ff3_r;

    // -------------------------------------------------------------
    // synchroniser chain
    // -------------------------------------------------------------
    // ff1 feeds only ff2; the agree test looks at ff2 and ff3
    always_ff @(posedge clock) begin
        if (reset) begin
            ff1_r <= 1'b0;
            ff2_r <= 1'b0;
            ff3_r <= 1'b0;
            level <= 1'b0;
        end else begin
            ff1_r <= pin;
            ff2_r <= ff1_r;
            ff3_r <= ff2_r;
            if (ff2_r == ff3_r) begin
                level <= ff3_r;
            end
        end
    end
endmodule // rpr_pin_sync
`default_nettype wire

// ---- testbench/rpr_ir_src.sv ----
// Purpose: demodulated remote source
// Assumes: spans counted in sample ticks
// Notes: line idles high between frames
`timescale 1ns/1ns
`default_nettype none
module rpr_ir_src (
    // sample clock
    input wire logic samp_clk,
    // remote line
    output logic remote_pin
);
    initial remote_pin = 1'h1; // idle level
    // one low span then one high span
    task automatic pulse(input int lo, input int hi);
        repeat (lo) @(posedge samp_clk) remote_pin <= 1'h0;
        repeat (hi) @(posedge samp_clk) remote_pin <= 1'h1;
    endtask
endmodule // rpr_ir_src
`default_nettype wire

// ---- testbench/tb.sv ----
// Purpose: self-checking bench for the pulse receiver
// Assumes: sample clocks derived from the bus clock
// Notes: sent bits kept in a queue as the reference
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clock, reset, hwrite, lf_clk_pin, timer_out_pin, use_timer;
    logic hreadyout, hresp, irq;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    wire logic remote_pin;
    int bad_count = 0, num_checks = 0, irq_n = 0, lf_n = 0, tm_n = 0, n0 = 0;
    int seed = 32'h17B2071C;
    bit q[$];
    rpr_receiver i_rpr_receiver (.clock(clock), .reset(reset), .hsel(1'h1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .lf_clk_pin(lf_clk_pin), .timer_out_pin(timer_out_pin), .remote_pin(remote_pin),
        .irq(irq));
    rpr_ir_src i_rpr_ir_src (.samp_clk(use_timer ? timer_out_pin : lf_clk_pin),
        .remote_pin(remote_pin));
    initial begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end
    // sample clocks of 40 and 30 bus clocks; interrupt pulse count
    always @(posedge clock) begin
        lf_n <= (lf_n == 19) ? 0 : lf_n + 1;
        tm_n <= (tm_n == 14) ? 0 : tm_n + 1;
        if (lf_n == 19) lf_clk_pin <= ~lf_clk_pin;
        if (tm_n == 14) timer_out_pin <= ~timer_out_pin;
        if (irq === 1'h1) irq_n <= irq_n + 1;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one single-word transfer; holds each phase until hready is seen high
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clock); while (hreadyout !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'h1);
        rd = hrdata;
    endtask
    task automatic rchk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        check(rd & m, e);
        check({31'h0, hresp}, 32'h0);
    endtask
    // leader, n random symbols (one bit in cycle mode, a two-bit pattern in phase mode),
    // closing fall, long low then high so either end trigger can complete the frame
    task automatic frame(input int n, input bit ph);
        int s;
        q = {};
        i_rpr_ir_src.pulse(14, 8);
        repeat (n) begin
            s = $unsigned($random(seed)) % (ph ? 3 : 2);
            if (ph) q.push_back(s == 2);
            q.push_back(s == 1);
            i_rpr_ir_src.pulse(2, ph ? 2 + 3 * s : 2 + 4 * s);
        end
        i_rpr_ir_src.pulse(20, 12);
        @(posedge clock);
    endtask
    // reference word: newest bit at bit 0
    function automatic logic [31:0] word(input int base);
        logic [31:0] w;
        w = 32'h0;
        for (int i = 0; i < 32; i++)
            if (base + i < q.size()) w[i] = q[q.size() - 1 - base - i];
        return w;
    endfunction
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clock);
        bad_count++;
        final_report();
    end
    initial begin
        reset = 1'h1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hwdata = 32'h0;
        lf_clk_pin = 1'h0;
        timer_out_pin = 1'h0;
        use_timer = 1'h0;
        repeat (6) @(posedge clock);
        reset <= 1'h0;
        @(posedge clock);
        // reset values and one unmapped word
        for (int i = 0; i < 10; i++)
            rchk(i == 9 ? 32'h40 : 32'(i * 4), '1, i == 6 ? 32'h0000FFFF : 32'h0);
        bus(1'h1, 32'h14, 32'h08050403);
        rchk(32'h14, '1, 32'h0);
        bus(1'h1, 32'h0, 32'h3);
        bus(1'h1, 32'h14, 32'h08050403);
        bus(1'h1, 32'h18, 32'h8000FF14);
        bus(1'h1, 32'h1C, 32'h00000306);
        bus(1'h1, 32'h4, 32'h1);
        n0 = irq_n;
        frame(10, 1'h0);
        check(irq_n - n0, 2);
        rchk(32'h8, '1, word(0));
        rchk(32'hC, '1, 32'h0);
        rchk(32'h10, '1, 32'h0);
        rchk(32'h24, 32'hF0FF, 32'h208A);
        // block off keeps settings and freezes writes
        bus(1'h1, 32'h0, 32'h2);
        bus(1'h1, 32'h14, 32'h11111111);
        rchk(32'h14, '1, 32'h08050403);
        bus(1'h1, 32'h0, 32'h3);
        bus(1'h1, 32'h34, 32'h1);
        use_timer <= 1'h1;
        bus(1'h1, 32'h18, 32'h4000FF14);
        n0 = irq_n;
        frame(40, 1'h0);
        check(irq_n - n0, 43);
        rchk(32'h8, '1, word(0));
        rchk(32'hC, 32'hFF, word(32) & 32'hFF);
        rchk(32'h24, 32'hF0FF, 32'h20A8);
        // phase mode, filtered input, frame ended by an excess low
        bus(1'h1, 32'h4, 32'h0);
        bus(1'h1, 32'h18, 32'h01000CFF);
        bus(1'h1, 32'h1C, 32'h00000805);
        bus(1'h1, 32'h20, 32'h00000002);
        bus(1'h1, 32'h4, 32'h1);
        n0 = irq_n;
        frame(12, 1'h1);
        check(irq_n - n0, 1);
        rchk(32'h8, '1, word(0));
        rchk(32'h24, 32'hF0FF, 32'h4098);
        final_report();
    end
endmodule // tb
`default_nettype wire
